// ---- design/sar_adc_readout.sv ----
`timescale 1ns/100ps
`include "sar_map.svh"
// Behaviour
// RULE_01: Select falling edge starts an internal conversion
// RULE_02: Input value held at select falling edge
// RULE_03: Shutdown right after conversion until next start
// RULE_04: Output driven only while select low
// RULE_05: New bit after each shift clock fall
// RULE_06: Host holds shift clock low at select fall
// RULE_07: Sixteen-bit two's complement result coding
// RULE_08: Zero differential input gives all-zero code
// RULE_09: Saturate at full-scale codes, never wrap
// RULE_10: Result belongs to the current conversion
// RULE_11: Host respects acquisition time and throughput
// RULE_12: Host clocks sixteen bits, MSB first
module sar_adc_readout
(
    input wire logic clk_sys, // System clock, 50 MHz
    input wire logic rst, // Async reset, active high
    input wire logic conversion_select_n, // Select pin, active low
    input wire logic serial_shift_clock, // Host shift clock pin
    input wire sar_pkg::sar_input_t input_diff, // Differential input, signed
    output logic serial_result_out, // Serial data out
    output logic serial_result_out_en_n, // Data pin enable, low drives
    output logic shutdown // High in low-power state
);
    import sar_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    // Select chain and its edge
    logic sel_meta;
    logic sel_sync;
    logic sel_last;
    logic sel_fall;

    // Shift clock chain and its edge
    logic sck_meta;
    logic sck_sync;
    logic sck_last;
    logic sck_fall;

    // Falling edge from the previous and present synchronised levels
    function automatic logic edge_fell(input logic prev, input logic curr);
        return prev & ~curr;
    endfunction

    // Select chain: two stages, then one more flop for edges
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            // Idle high, so no false start after reset
            sel_meta <= 1'b1;
            sel_sync <= 1'b1;
            sel_last <= 1'b1;
        end
        else
        begin
            sel_meta <= conversion_select_n;
            sel_sync <= sel_meta;
            sel_last <= sel_sync;
        end
    end

    // Shift clock chain: two stages, then one more flop for edges
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            // Parked low, so no false shift after reset
            sck_meta <= 1'b0;
            sck_sync <= 1'b0;
            sck_last <= 1'b0;
        end
        else
        begin
            sck_meta <= serial_shift_clock;
            sck_sync <= sck_meta;
            sck_last <= sck_sync;
        end
    end

    // Edge pulses, one clock wide
    assign sel_fall = edge_fell(sel_last, sel_sync);
    assign sck_fall = edge_fell(sck_last, sck_sync);

    ////////////////////////////////////////////////////////////////////////
    // Converter core
    sar_conv_if cv ();

    sar_approx u_approx
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .cv(cv.conv)
    );

    ////////////////////////////////////////////////////////////////////////
    // Conversion control
    // Converter state, frozen sample and start pulse
    sar_state_e state;
    sar_state_e next_state;
    sar_input_t held;
    sar_input_t next_held;
    logic start;
    logic next_start;
    logic next_shutdown;
    logic conv_begin;
    logic conv_end;

    // Core hookup: frozen sample and one-cycle start
    assign cv.start = start;
    assign cv.sample = held;

    // Conversion boundaries, shared with the readout
    assign conv_begin = (state == SAR_ST_SHUTDOWN) && sel_fall; // [RULE_01]
    assign conv_end = (state == SAR_ST_CONVERT) && cv.done; // [RULE_03]

    // Next conversion state
    always_comb
    begin
        next_state = state;
        next_held = held;
        next_start = 1'b0;
        next_shutdown = shutdown;
        unique case (state)
            SAR_ST_SHUTDOWN:
            begin
                if (conv_begin)
                begin
                    // Freeze the input and kick off the search
                    next_held = input_diff; // [RULE_02]
                    next_start = 1'b1; // [RULE_01]
                    next_state = SAR_ST_CONVERT;
                    next_shutdown = 1'b0;
                end
            end
            SAR_ST_CONVERT:
            begin
                // Select falls during a conversion are ignored
                if (conv_end)
                begin
                    next_state = SAR_ST_SHUTDOWN;
                    next_shutdown = 1'b1; // [RULE_03]
                end
            end
        endcase
    end

    // Conversion registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= SAR_ST_SHUTDOWN;
            held <= '0;
            start <= 1'b0;
            shutdown <= 1'b1;
        end
        else
        begin
            state <= next_state;
            held <= next_held;
            start <= next_start;
            shutdown <= next_shutdown;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial readout
    // Shifter, accepted shift edge and next pin values
    sar_code_t shreg;
    sar_code_t next_shreg;
    logic shift_take;
    logic next_dout;
    logic next_en_n;

    // Shift falls count only while selected and not converting
    assign shift_take = (state == SAR_ST_SHUTDOWN) && sck_fall && !sel_sync;

    // Next shifter, data and enable
    always_comb
    begin
        next_shreg = shreg;
        next_dout = serial_result_out;
        // Pin released whenever select is high
        next_en_n = sel_sync; // [RULE_04]
        if (conv_begin)
        begin
            // Data low while the search runs
            next_dout = 1'b0;
        end
        else if (conv_end)
        begin
            // Fresh result loads straight into the shifter
            next_shreg = cv.code; // [RULE_10]
            next_dout = cv.code[`SAR_BITS-1]; // [RULE_12]
        end
        else if (shift_take)
        begin
            // Next bit after each falling shift edge, zeros behind
            next_shreg = {shreg[`SAR_BITS-2:0], 1'b0}; // [RULE_05] [RULE_12]
            next_dout = shreg[`SAR_BITS-2]; // [RULE_05]
        end
    end

    // Readout registers; outputs come straight from flops
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            shreg <= `SAR_RESET_CODE;
            serial_result_out <= 1'b0;
            serial_result_out_en_n <= 1'b1;
        end
        else
        begin
            shreg <= next_shreg;
            serial_result_out <= next_dout;
            serial_result_out_en_n <= next_en_n;
        end
    end
endmodule // sar_adc_readout

// ---- design/sar_map.svh ----
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH
// Result width and code points
`define SAR_BITS 16
`define SAR_IN_BITS 18
`define SAR_CODE_MAX 16'h7fff
`define SAR_CODE_MIN 16'h8000
`define SAR_OFFSET 16'h8000
`define SAR_RESET_CODE 16'h0000
// Host-side timing, in ns, with derived cycle counts at the system clock
`define SAR_CLK_NS 20
`define SAR_CONV_PERIOD_NS 10000
`define SAR_ACQ_NS 400
`define SAR_ACQ_CYCLES ((`SAR_ACQ_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_CONV_PERIOD_CYCLES ((`SAR_CONV_PERIOD_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`endif

// ---- design/sar_pkg.sv ----
`include "sar_map.svh"
package sar_pkg;
    typedef logic signed [`SAR_IN_BITS-1:0] sar_input_t;
    typedef logic [`SAR_BITS-1:0] sar_code_t;
    typedef enum logic [0:0] {
        SAR_ST_SHUTDOWN = 1'b0,
        SAR_ST_CONVERT = 1'b1
    } sar_state_e;
endpackage

// ---- design/sar_conv_if.sv ----
`timescale 1ns/100ps
interface sar_conv_if;
    import sar_pkg::*;
    logic start; // One-cycle start pulse
    sar_input_t sample; // Held differential value
    logic done; // One-cycle completion pulse
    sar_code_t code; // Two's complement result
    modport ctrl (output start, output sample, input done, input code);
    modport conv (input start, input sample, output done, output code);
endinterface

// ---- design/sar_approx.sv ----
`timescale 1ns/100ps
`include "sar_map.svh"
module sar_approx
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Async reset, active high
    sar_conv_if.conv cv // Start, sample and result
);
    import sar_pkg::*;

    logic [`SAR_BITS-1:0] target;
    logic [`SAR_BITS-1:0] trial;
    logic [`SAR_BITS-1:0] bit_sel;
    logic busy;
    logic [`SAR_BITS-1:0] next_target;
    logic [`SAR_BITS-1:0] next_trial;
    logic [`SAR_BITS-1:0] next_bit_sel;
    logic next_busy;
    logic next_done;
    sar_code_t next_code;
    logic [`SAR_BITS-1:0] sat;
    logic [`SAR_BITS-1:0] cand;

    ////////////////////////////////////////////////////////////////////////
    // Clamp the sample to the code range, then bit-by-bit search
    always_comb
    begin
        if (cv.sample > $signed({{(`SAR_IN_BITS-`SAR_BITS){1'b0}}, `SAR_CODE_MAX}))
            sat = `SAR_CODE_MAX; // [RULE_09]
        else if (cv.sample < $signed({{(`SAR_IN_BITS-`SAR_BITS){1'b1}}, `SAR_CODE_MIN}))
            sat = `SAR_CODE_MIN; // [RULE_09]
        else
            sat = cv.sample[`SAR_BITS-1:0];
        cand = trial | bit_sel;
        next_target = target;
        next_trial = trial;
        next_bit_sel = bit_sel;
        next_busy = busy;
        next_done = 1'b0;
        next_code = cv.code;
        if (cv.start)
        begin
            // Offset binary so the search is unsigned
            next_target = sat ^ `SAR_OFFSET;
            next_trial = '0;
            next_bit_sel = `SAR_OFFSET; // MSB first
            next_busy = 1'b1;
        end
        else if (busy)
        begin
            if (cand <= target)
                next_trial = cand;
            next_bit_sel = bit_sel >> 1;
            if (bit_sel[0])
            begin
                next_busy = 1'b0;
                next_done = 1'b1;
                // Back to two's complement; midscale gives zero
                next_code = (cand <= target ? cand : trial) ^ `SAR_OFFSET; // [RULE_07] [RULE_08]
            end
        end
    end

    // Register the search state
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            target <= '0;
            trial <= '0;
            bit_sel <= '0;
            busy <= 1'b0;
            cv.done <= 1'b0;
            cv.code <= `SAR_RESET_CODE;
        end
        else
        begin
            target <= next_target;
            trial <= next_trial;
            bit_sel <= next_bit_sel;
            busy <= next_busy;
            cv.done <= next_done;
            cv.code <= next_code;
        end
    end
endmodule // sar_approx

// ---- tb/sar_adc_readout_chk.sv ----
`timescale 1ns/100ps
module sar_adc_readout_chk
(
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic conversion_select_n, // Select
    input wire logic serial_shift_clock, // Shift clock
    input wire sar_pkg::sar_input_t input_diff, // Input
    input wire logic serial_result_out, // Data
    input wire logic serial_result_out_en_n, // Data enable
    input wire logic shutdown // Low power
);
    import sar_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // Conversion start and length
    property p_start; $fell(conversion_select_n) && shutdown |-> ##[1:6] !shutdown; endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_len; $fell(shutdown) |-> (!shutdown)[*8] ##[8:11] shutdown; endproperty
    a_len: assert property (p_len) else $error("bad length");
    property p_stay; shutdown && conversion_select_n && $past(conversion_select_n, 3) |=> shutdown;
    endproperty
    a_stay: assert property (p_stay) else $error("woke idle");
    property p_idle; $fell(rst) |-> shutdown && serial_result_out_en_n; endproperty
    a_idle: assert property (p_idle) else $error("bad idle");
    ////////////////////////////////////////////////////////////////
    // Pin drive and shifting
    property p_hiz; conversion_select_n[*5] |-> serial_result_out_en_n; endproperty
    a_hiz: assert property (p_hiz) else $error("pin driven");
    property p_drv; (!conversion_select_n)[*6] |-> !serial_result_out_en_n; endproperty
    a_drv: assert property (p_drv) else $error("pin idle");
    property p_hold; serial_shift_clock[*4] ##0 shutdown |-> $stable(serial_result_out); endproperty
    a_hold: assert property (p_hold) else $error("bit moved");
    property p_res; $rose(shutdown) |-> !serial_result_out_en_n; endproperty
    a_res: assert property (p_res) else $error("result hidden");
    c_conv: cover property ($rose(shutdown));
    c_shift: cover property ($fell(serial_shift_clock) && !serial_result_out_en_n);
    c_off: cover property ($rose(serial_result_out_en_n));
endmodule // sar_adc_readout_chk
bind sar_adc_readout sar_adc_readout_chk sar_adc_readout_chk_inst
(.clk_sys(clk_sys), .rst(rst), .conversion_select_n(conversion_select_n),
.serial_shift_clock(serial_shift_clock), .input_diff(input_diff),
.serial_result_out(serial_result_out), .serial_result_out_en_n(serial_result_out_en_n),
.shutdown(shutdown));

// ---- tb/sar_host_model.sv ----
`timescale 1ns/100ps
module sar_host_model
(
    input wire logic clk_sys, // Clock
    input wire logic serial_data, // Resolved data pin
    output logic conversion_select_n, // Select
    output logic serial_shift_clock // Shift clock
);
    import sar_pkg::*;
    // Deselected, shift clock parked low
    initial
    begin
        conversion_select_n = 1'b1;
        serial_shift_clock = 1'b0;
    end
    // Select drop with shift clock already low
    task automatic start_conv;
        @(negedge clk_sys);
        conversion_select_n = 1'b0;
    endtask
    // Bit taken just before each fall, while it still holds
    task automatic read_word(output sar_code_t w);
        repeat (15) @(negedge clk_sys);
        for (int i = 0; i < 16; i++)
        begin
            serial_shift_clock = 1'b1;
            repeat (4) @(negedge clk_sys);
            w = {w[14:0], serial_data};
            serial_shift_clock = 1'b0;
            repeat (4) @(negedge clk_sys);
        end
        conversion_select_n = 1'b1;
        repeat (440) @(negedge clk_sys);
    endtask
endmodule // sar_host_model

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import sar_pkg::*;
    logic clk_sys;
    logic rst;
    sar_input_t input_diff;
    logic sel_n;
    logic sck;
    logic dout;
    logic dout_en_n;
    logic shutdown;
    wire serial_pin;
    int miscompares = 0;
    int checks_done = 0;
    // Pin floats while released
    assign serial_pin = dout_en_n ? 1'bz : dout;
    sar_adc_readout sar_adc_readout_inst (.clk_sys(clk_sys), .rst(rst),
        .conversion_select_n(sel_n), .serial_shift_clock(sck), .input_diff(input_diff),
        .serial_result_out(dout), .serial_result_out_en_n(dout_en_n), .shutdown(shutdown));
    sar_host_model sar_host_model_inst (.clk_sys(clk_sys), .serial_data(serial_pin),
        .conversion_select_n(sel_n), .serial_shift_clock(sck));
    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One conversion; input moved after capture
    task automatic convert(input sar_input_t v, input sar_code_t e);
        sar_code_t w;
        @(negedge clk_sys);
        input_diff = v;
        chk("idle", 16'h0001, {15'h0, shutdown});
        chk("pin", {15'h0, 1'bz}, {15'h0, serial_pin});
        sar_host_model_inst.start_conv();
        repeat (10) @(negedge clk_sys);
        input_diff = ~v;
        chk("busy", 16'h0000, {15'h0, shutdown});
        chk("drive", 16'h0000, {15'h0, dout_en_n});
        sar_host_model_inst.read_word(w);
        chk("code", e, w);
    endtask
    task automatic test_midscale;
        convert(18'h00000, 16'h0000);
        convert(18'h00001, 16'h0001);
        convert(18'h3ffff, 16'hffff);
        $display("test_midscale done");
    endtask
    task automatic test_saturate;
        convert(18'h07fff, 16'h7fff);
        convert(18'h09c40, 16'h7fff);
        convert(18'h38001, 16'h8001);
        convert(18'h363c0, 16'h8000);
        $display("test_saturate done");
    endtask
    task automatic test_back_to_back;
        convert(18'h01234, 16'h1234);
        convert(18'h3edcc, 16'hedcc);
        $display("test_back_to_back done");
    endtask
    // Main sequence
    initial
    begin
        rst = 1'b1;
        input_diff = '0;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        test_midscale();
        test_saturate();
        test_back_to_back();
        tally_and_finish();
    end
    // Watchdog
    initial
    begin
        repeat (12000) @(posedge clk_sys);
        miscompares++;
        tally_and_finish();
    end
endmodule // tb_top
